// ---- design/asx_dev.sv ----
// Device end: registers, transmitter with preamble and break, receiver
// Behaviour
// - Frame is start, 8/9 data, stop
// - Thirteen-bit divisor counter, values 1 to 8191
// - Zero divisor stops the generator
// - Tick is 16x baud; tx divides again
// - Tx and rx independent, separate buffers
// - Second unread character dropped, overrun set
// - Enable rising edge queues all-ones preamble
// - Frame gets start 0 low, stop 1 high
// - Parity replaces character MSB when enabled
// - Empty flag set when buffer hands over
// - Empty flag and enable raise interrupt
// - Empty cleared by status read then write
// - Enabled idle transmitter drives 1
// - Disable finishes frame, then releases pin
// - Software waits for empty before disabling
// - Toggle enable between messages for preamble
// - Preamble length follows character length
// - Send-break loads all-zero frame
// - Break repeats; after clearing, one 1
// - Break is zero data and zero stop
// - Break sets framing, full, clears data
// - Two stop bits done by software MSB
module asx_dev #(
	parameter int DIV_W = asx_pkg::DIV_W
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [asx_pkg::ADDR_W-1:0] addr_i,
	input wire logic [asx_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [asx_pkg::DATA_W-1:0] rdata_o,
	output logic tx_irq_o,
	asx_link_if.dev link
);
	typedef enum logic [1:0] {TX_OFF, TX_IDLE, TX_SHIFT} asx_txs_t;
	typedef enum logic [1:0] {RX_HUNT, RX_BITS} asx_rxs_t;
	typedef struct packed {
		logic [6:0] ctrl;
		logic [DIV_W-1:0] div;
		logic [8:0] tx_buf;
		logic tx_empty;
		logic stat_seen;
		logic preamble_due;
		logic one_due;
		asx_txs_t txs;
		logic [asx_pkg::FRAME_MAX-1:0] sh;
		logic [3:0] bits_left;
		logic [3:0] tx_ovs;
		logic tx_line;
		logic tx_oe;
		logic [8:0] rx_data;
		logic rx_full;
		logic ovr;
		logic frm;
		logic par_err;
		asx_rxs_t rxs;
		logic [3:0] rx_ovs;
		logic [3:0] rx_cnt;
		logic [asx_pkg::FRAME_MAX-1:0] rx_sh;
		logic [1:0] rx_sync;
		logic [asx_pkg::DATA_W-1:0] rdata;
	} asx_dev_t;
	asx_dev_t st_reg;
	asx_dev_t st_next;
	logic tick;
	logic long_mode;
	logic par_bit;
	logic [3:0] flen;
	logic [8:0] chr;
	logic rx_bit;
	logic [asx_pkg::FRAME_MAX-1:0] rx_fr;
	logic [asx_pkg::DATA_W-1:0] stat_word;

	asx_baud_gen #(.DIV_W(DIV_W)) u_baud (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.divisor_i(st_reg.div),
		.tick_o(tick)
	);

	always_comb begin
		st_next = st_reg;
		long_mode = st_reg.ctrl[asx_pkg::CB_LONG];
		flen = long_mode ? asx_pkg::FRAME_LONG : asx_pkg::FRAME_SHORT;
		chr = st_reg.tx_buf;
		if (!long_mode) begin
			chr[8] = 1'b0;
		end
		par_bit = (long_mode ? ^chr[7:0] : ^chr[6:0])
			^ st_reg.ctrl[asx_pkg::CB_PAR_ODD];
		if (st_reg.ctrl[asx_pkg::CB_PAR_EN]) begin
			if (long_mode) begin
				chr[8] = par_bit;
			end else begin
				chr[7] = par_bit;
			end
		end
		rx_bit = st_reg.rx_sync[1];
		rx_fr = {rx_bit, st_reg.rx_sh[asx_pkg::FRAME_MAX-1:1]};
		stat_word = '0;
		stat_word[asx_pkg::SB_TXE] = st_reg.tx_empty;
		stat_word[asx_pkg::SB_RXF] = st_reg.rx_full;
		stat_word[asx_pkg::SB_OVR] = st_reg.ovr;
		stat_word[asx_pkg::SB_FRM] = st_reg.frm;
		stat_word[asx_pkg::SB_PAR] = st_reg.par_err;
		stat_word[asx_pkg::SB_ACT] = (st_reg.rxs == RX_BITS);
		stat_word[asx_pkg::SB_TXIDLE] = (st_reg.txs != TX_SHIFT);
		st_next.rx_sync = {st_reg.rx_sync[0], link.far_tx};
		st_next.rdata = '0;

		// Register reads
		if (rd_i) begin
			unique case (addr_i)
				asx_pkg::ADDR_DATA: begin
					st_next.rdata = {7'h00, st_reg.rx_data};
					st_next.rx_full = 1'b0;
				end
				asx_pkg::ADDR_CTRL: st_next.rdata = {9'h000, st_reg.ctrl};
				asx_pkg::ADDR_STAT: begin
					st_next.rdata = stat_word;
					st_next.stat_seen = 1'b1;
				end
				asx_pkg::ADDR_BAUD: st_next.rdata = {3'h0, st_reg.div};
				default: st_next.rdata = '0;
			endcase
		end
		if (wr_i) begin
			unique case (addr_i)
				asx_pkg::ADDR_DATA: begin
					st_next.tx_buf = wdata_i[8:0];
					if (st_reg.stat_seen) begin
						st_next.tx_empty = 1'b0;
						st_next.stat_seen = 1'b0;
					end
				end
				asx_pkg::ADDR_CTRL: begin
					st_next.ctrl = wdata_i[6:0];
					if (wdata_i[asx_pkg::CB_TX_EN]
						&& !st_reg.ctrl[asx_pkg::CB_TX_EN]) begin
						st_next.preamble_due = 1'b1;
					end
					if (!wdata_i[asx_pkg::CB_BREAK]
						&& st_reg.ctrl[asx_pkg::CB_BREAK]) begin
						st_next.one_due = 1'b1;
					end
				end
				asx_pkg::ADDR_STAT: begin
					if (st_reg.stat_seen) begin
						st_next.ovr = 1'b0;
						st_next.frm = 1'b0;
						st_next.par_err = 1'b0;
						st_next.stat_seen = 1'b0;
					end
				end
				asx_pkg::ADDR_BAUD: st_next.div = wdata_i[DIV_W-1:0];
				default: ;
			endcase
		end

		// Transmitter, one bit per 16 ticks
		unique case (st_reg.txs)
			TX_OFF: begin
				st_next.tx_oe = 1'b0;
				st_next.tx_line = 1'b1;
				if (st_reg.ctrl[asx_pkg::CB_TX_EN]) begin
					st_next.txs = TX_IDLE;
				end
			end
			TX_IDLE: begin
				st_next.tx_oe = 1'b1;
				st_next.tx_line = 1'b1;
				st_next.tx_ovs = '0;
				if (!st_reg.ctrl[asx_pkg::CB_TX_EN]) begin
					st_next.txs = TX_OFF;
				end else if (tick) begin
					st_next.bits_left = flen;
					st_next.txs = TX_SHIFT;
					if (st_reg.one_due) begin
						// Single mark bit after a break
						st_next.sh = '1;
						st_next.bits_left = 4'h1;
						st_next.one_due = 1'b0;
					end else if (st_reg.ctrl[asx_pkg::CB_BREAK]) begin
						st_next.sh = '0;
					end else if (st_reg.preamble_due) begin
						st_next.sh = '1;
						st_next.preamble_due = 1'b0;
					end else if (!st_reg.tx_empty) begin
						if (long_mode) begin
							st_next.sh = {1'b1, chr, 1'b0};
						end else begin
							st_next.sh = {2'b11, chr[7:0], 1'b0};
						end
						st_next.tx_empty = 1'b1;
						st_next.stat_seen = 1'b0;
					end else begin
						st_next.txs = TX_IDLE;
					end
					// First bit drives now so it lasts a full 16 ticks
					if (st_next.txs == TX_SHIFT) begin
						st_next.tx_line = st_next.sh[0];
					end
				end
			end
			TX_SHIFT: begin
				st_next.tx_line = st_reg.sh[0];
				if (tick) begin
					st_next.tx_ovs = st_reg.tx_ovs + 1'b1;
					if (st_reg.tx_ovs == asx_pkg::OVS_LAST) begin
						st_next.sh = {1'b1, st_reg.sh[asx_pkg::FRAME_MAX-1:1]};
						st_next.bits_left = st_reg.bits_left - 1'b1;
						if (st_reg.bits_left == 4'h1
							&& st_reg.ctrl[asx_pkg::CB_BREAK]
							&& st_reg.ctrl[asx_pkg::CB_TX_EN]
							&& !st_reg.one_due) begin
							// Breaks back to back, no mark gap between
							st_next.sh = '0;
							st_next.bits_left = flen;
							st_next.tx_line = 1'b0;
						end else if (st_reg.bits_left == 4'h1) begin
							st_next.txs = TX_IDLE;
							st_next.tx_line = 1'b1;
						end else begin
							st_next.tx_line = st_reg.sh[1];
						end
					end
				end
			end
			default: st_next.txs = TX_OFF;
		endcase

		// Receiver, middle-of-bit sample
		unique case (st_reg.rxs)
			RX_HUNT: begin
				st_next.rx_ovs = '0;
				if (tick && !rx_bit && st_reg.ctrl[asx_pkg::CB_RX_EN]) begin
					st_next.rxs = RX_BITS;
					st_next.rx_cnt = flen;
					st_next.rx_sh = '0;
				end
			end
			RX_BITS: begin
				if (tick) begin
					st_next.rx_ovs = st_reg.rx_ovs + 1'b1;
					if (st_reg.rx_ovs == asx_pkg::OVS_MID) begin
						st_next.rx_sh = rx_fr;
						st_next.rx_cnt = st_reg.rx_cnt - 1'b1;
						if (st_reg.rx_cnt == 4'h1) begin
							st_next.rxs = RX_HUNT;
							if (!long_mode) begin
								rx_fr = {1'b0, rx_fr[asx_pkg::FRAME_MAX-1:1]};
							end
							if (st_reg.rx_full) begin
								st_next.ovr = 1'b1;
							end else begin
								st_next.rx_full = 1'b1;
								st_next.frm = long_mode ? !rx_fr[10]
									: !rx_fr[9];
								st_next.rx_data = (rx_fr[10:1] == '0)
									? 9'h000 : rx_fr[9:1];
								if (!long_mode) begin
									st_next.rx_data[8] = 1'b0;
								end
							end
						end
					end
				end
			end
			default: st_next.rxs = RX_HUNT;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
			st_reg.tx_line <= 1'b1;
			st_reg.tx_empty <= 1'b1;
			st_reg.rx_sync <= 2'b11;
			st_reg.div <= asx_pkg::DIV_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_o = st_reg.rdata;
	assign tx_irq_o = st_reg.tx_empty & st_reg.ctrl[asx_pkg::CB_TXIE];
	assign link.dev_tx = st_reg.tx_line;
	assign link.dev_tx_oe = st_reg.tx_oe;
endmodule

// ---- design/asx_pkg.sv ----
// Shared constants for the asynchronous serial unit
package asx_pkg;
	localparam int DIV_W = 13;
	localparam int OVS = 16;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam logic [DIV_W-1:0] DIV_RESET = 13'h0000;
	localparam logic [ADDR_W-1:0] ADDR_DATA = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_BAUD = 3'h3;
	localparam int CB_TX_EN = 0;
	localparam int CB_BREAK = 1;
	localparam int CB_TXIE = 2;
	localparam int CB_LONG = 3;
	localparam int CB_PAR_EN = 4;
	localparam int CB_PAR_ODD = 5;
	localparam int CB_RX_EN = 6;
	localparam int SB_TXE = 0;
	localparam int SB_RXF = 1;
	localparam int SB_OVR = 2;
	localparam int SB_FRM = 3;
	localparam int SB_PAR = 4;
	localparam int SB_ACT = 5;
	localparam int SB_TXIDLE = 6;
	localparam int FRAME_MAX = 11;
	localparam int CHAR_MAX = 9;
	localparam logic [3:0] FRAME_SHORT = 4'hA;
	localparam logic [3:0] FRAME_LONG = 4'hB;
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] OVS_MID = 4'h8;
	localparam logic [3:0] FRAME_SHORT_OVS_START = 4'h0;
endpackage

// ---- design/asx_link_if.sv ----
// Serial link between the device end and the far end
interface asx_link_if;
	logic dev_tx;
	logic dev_tx_oe;
	logic far_tx;
	logic far_tx_oe;
	modport dev (output dev_tx, output dev_tx_oe, input far_tx, input far_tx_oe);
	modport far (input dev_tx, input dev_tx_oe, output far_tx, output far_tx_oe);
endinterface

// ---- design/asx_baud_gen.sv ----
// Baud divider producing the sixteen-times oversampling tick
module asx_baud_gen #(
	parameter int DIV_W = asx_pkg::DIV_W
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [DIV_W-1:0] divisor_i,
	output logic tick_o
);
	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic tick;
	} asx_bg_t;
	asx_bg_t st_reg;
	asx_bg_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (divisor_i == '0) begin
			st_next.cnt = '0;
		end else if (st_reg.cnt >= divisor_i - 1'b1) begin
			st_next.cnt = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.cnt = st_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick_o = st_reg.tick;
endmodule

// ---- design/asx_far.sv ----
// Far end: plain frame sender and receiver on a fixed divisor
module asx_far #(
	parameter int DIV_W = asx_pkg::DIV_W
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [DIV_W-1:0] divisor_i,
	input wire logic long_i,
	input wire logic [8:0] send_data_i,
	input wire logic send_valid_i,
	output logic send_ready_o,
	output logic [8:0] recv_data_o,
	output logic recv_break_o,
	output logic recv_valid_o,
	asx_link_if.far link
);
	typedef struct packed {
		logic busy;
		logic [asx_pkg::FRAME_MAX-1:0] sh;
		logic [3:0] left;
		logic [3:0] ovs;
		logic line;
		logic rbusy;
		logic [3:0] rovs;
		logic [3:0] rleft;
		logic [asx_pkg::FRAME_MAX-1:0] rsh;
		logic [1:0] sync;
		logic [8:0] rdata;
		logic rbrk;
		logic rvalid;
	} asx_far_t;
	asx_far_t st_reg;
	asx_far_t st_next;
	logic tick;
	logic bitv;
	logic [3:0] flen;
	logic [asx_pkg::FRAME_MAX-1:0] fr;

	asx_baud_gen #(.DIV_W(DIV_W)) u_baud (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.divisor_i(divisor_i),
		.tick_o(tick)
	);

	always_comb begin
		st_next = st_reg;
		st_next.rvalid = 1'b0;
		st_next.sync = {st_reg.sync[0], link.dev_tx_oe ? link.dev_tx : 1'b1};
		bitv = st_reg.sync[1];
		flen = long_i ? asx_pkg::FRAME_LONG : asx_pkg::FRAME_SHORT;
		fr = {bitv, st_reg.rsh[asx_pkg::FRAME_MAX-1:1]};
		if (!st_reg.busy) begin
			st_next.line = 1'b1;
			// Start on a tick so the start bit is a whole bit long
			if (send_valid_i && tick) begin
				st_next.busy = 1'b1;
				st_next.ovs = '0;
				st_next.left = flen;
				st_next.sh = long_i ? {1'b1, send_data_i, 1'b0}
					: {2'b11, send_data_i[7:0], 1'b0};
				st_next.line = 1'b0;
			end
		end else if (tick) begin
			st_next.ovs = st_reg.ovs + 1'b1;
			if (st_reg.ovs == asx_pkg::OVS_LAST) begin
				st_next.sh = {1'b1, st_reg.sh[asx_pkg::FRAME_MAX-1:1]};
				st_next.left = st_reg.left - 1'b1;
				st_next.line = st_reg.sh[1];
				if (st_reg.left == 4'h1) begin
					st_next.busy = 1'b0;
					st_next.line = 1'b1;
				end
			end
		end
		if (!st_reg.rbusy) begin
			st_next.rovs = '0;
			if (tick && !bitv) begin
				st_next.rbusy = 1'b1;
				st_next.rleft = flen;
			end
		end else if (tick) begin
			st_next.rovs = st_reg.rovs + 1'b1;
			if (st_reg.rovs == asx_pkg::OVS_MID) begin
				st_next.rsh = fr;
				st_next.rleft = st_reg.rleft - 1'b1;
				if (st_reg.rleft == 4'h1) begin
					st_next.rbusy = 1'b0;
					if (!long_i) begin
						fr = {1'b0, fr[asx_pkg::FRAME_MAX-1:1]};
					end
					st_next.rdata = long_i ? fr[9:1] : {1'b0, fr[8:1]};
					st_next.rbrk = !(long_i ? fr[10] : fr[9])
						&& (fr[9:1] == '0);
					st_next.rvalid = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
			st_reg.line <= 1'b1;
			st_reg.sync <= 2'b11;
		end else begin
			st_reg <= st_next;
		end
	end

	assign send_ready_o = !st_reg.busy && tick;
	assign recv_data_o = st_reg.rdata;
	assign recv_break_o = st_reg.rbrk;
	assign recv_valid_o = st_reg.rvalid;
	assign link.far_tx = st_reg.line;
	assign link.far_tx_oe = 1'b1;
endmodule

// ---- tb/asx_monitor.sv ----
// Link-level checker watching both ends of the serial wire
module asx_monitor #(
	parameter int BIT = 32
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic dev_tx,
	input wire logic dev_tx_oe,
	input wire logic far_tx,
	input wire logic far_tx_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic dev_prev_reg, far_prev_reg, oe_prev_reg, pre_reg;
	logic [19:0] dev_run_reg, far_run_reg;
	// Wide counters so a long idle never wraps into a short run
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			dev_prev_reg <= 1'b1;
			far_prev_reg <= 1'b1;
			oe_prev_reg <= 1'b0;
			pre_reg <= 1'b0;
			dev_run_reg <= 20'h00000;
			far_run_reg <= 20'h00000;
		end else begin
			dev_prev_reg <= dev_tx;
			far_prev_reg <= far_tx;
			oe_prev_reg <= dev_tx_oe;
			dev_run_reg <= (dev_tx == dev_prev_reg) ? dev_run_reg + 20'h1 : 20'h1;
			far_run_reg <= (far_tx == far_prev_reg) ? far_run_reg + 20'h1 : 20'h1;
			if (dev_tx_oe && !oe_prev_reg)
				pre_reg <= 1'b1;
			else if (!dev_tx)
				pre_reg <= 1'b0;
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_dev_rise;
		dev_tx_oe && $past(dev_tx_oe) && $rose(dev_tx);
	endsequence
	sequence s_dev_fall;
		dev_tx_oe && $past(dev_tx_oe) && $fell(dev_tx);
	endsequence
	reset_pin_released_a: assert property ($fell(rst_i) |-> !dev_tx_oe && dev_tx)
		else $error("pin not released after reset");
	dev_bit_steps_a: assert property (s_dev_rise |-> dev_run_reg % BIT == 0)
		else $error("low run not whole bits");
	dev_mark_min_a: assert property (s_dev_fall |-> dev_run_reg >= BIT)
		else $error("high run shorter than a bit");
	preamble_len_a: assert property (s_dev_fall ##0 pre_reg |-> dev_run_reg >= 10*BIT)
		else $error("preamble too short");
	release_frame_end_a: assert property ($fell(dev_tx_oe) |-> $past(dev_tx) && dev_run_reg >= BIT)
		else $error("pin released mid frame");
	far_bit_steps_a: assert property (far_tx_oe && $rose(far_tx) |-> far_run_reg % BIT == 0)
		else $error("far low run not whole bits");
	far_stop_bit_a: assert property (far_tx_oe && $fell(far_tx) |-> far_run_reg >= BIT)
		else $error("far stop bit short");
	far_low_max_a: assert property (far_tx_oe && $rose(far_tx) |-> far_run_reg <= 10*BIT)
		else $error("far low run too long");
endmodule

// ---- tb/asx_bench.sv ----
// Self-checking bench joining device end and far end
module asx_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] C_TX = 16'h0001 << asx_pkg::CB_TX_EN;
	localparam logic [15:0] C_BRK = 16'h0001 << asx_pkg::CB_BREAK;
	localparam logic [15:0] C_IE = 16'h0001 << asx_pkg::CB_TXIE;
	localparam logic [15:0] C_LONG = 16'h0001 << asx_pkg::CB_LONG;
	localparam logic [15:0] C_PEN = 16'h0001 << asx_pkg::CB_PAR_EN;
	localparam logic [15:0] C_ODD = 16'h0001 << asx_pkg::CB_PAR_ODD;
	localparam logic [15:0] C_RX = 16'h0001 << asx_pkg::CB_RX_EN;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, irq;
	logic far_long = 1'b0, svalid = 1'b0, sready, fbrk, fvalid;
	logic [2:0] addr = 3'h0;
	logic [15:0] wdata = 16'h0000, rdata, st;
	logic [8:0] sdata = 9'h000, fdata;
	logic [9:0] rxq[$];
	int mismatches = 0, n_compared = 0;
	asx_link_if link();
	asx_dev u_asx_dev (.core_clk_i(clk), .rst_i(rst), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.tx_irq_o(irq), .link(link.dev));
	asx_far u_asx_far (.core_clk_i(clk), .rst_i(rst), .divisor_i(13'h0002),
		.long_i(far_long), .send_data_i(sdata), .send_valid_i(svalid),
		.send_ready_o(sready), .recv_data_o(fdata), .recv_break_o(fbrk),
		.recv_valid_o(fvalid), .link(link.far));
	asx_monitor #(.BIT(32)) u_asx_monitor (.core_clk_i(clk), .rst_i(rst),
		.dev_tx(link.dev_tx), .dev_tx_oe(link.dev_tx_oe),
		.far_tx(link.far_tx), .far_tx_oe(link.far_tx_oe));
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (fvalid === 1'b1)
			rxq.push_back({fbrk, fdata});
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// Status read first, so the data write also clears the empty flag
	task automatic put(input logic [15:0] d);
		rd_reg(asx_pkg::ADDR_STAT, st);
		wr_reg(asx_pkg::ADDR_DATA, d);
	endtask
	task automatic wait_rx(input int n);
		for (int i = 0; i < 3000 && rxq.size() < n; i++)
			@(posedge clk);
		chk(16'(rxq.size() >= n), 16'h0001);
	endtask
	task automatic far_send(input logic [8:0] d);
		@(posedge clk);
		sdata <= d;
		svalid <= 1'b1;
		do @(posedge clk); while (sready !== 1'b1);
		svalid <= 1'b0;
	endtask
	task automatic t_reset;
		rd_reg(asx_pkg::ADDR_STAT, st);
		chk(16'(st[asx_pkg::SB_TXE]), 16'h0001);
		rd_reg(asx_pkg::ADDR_BAUD, st);
		chk(st, 16'h0000);
		rd_reg(3'h7, st);
		chk(st, 16'h0000);
		chk(16'(link.dev_tx_oe), 16'h0000);
	endtask
	task automatic t_tx_basic;
		wr_reg(asx_pkg::ADDR_CTRL, C_TX | C_IE);
		#1 chk(16'(irq), 16'h0001);
		put(16'h00A5);
		#1 chk(16'(irq), 16'h0000);
		repeat (800) @(posedge clk);
		chk(16'(rxq.size()), 16'h0000);
		wr_reg(asx_pkg::ADDR_BAUD, 16'h0002);
		wait_rx(1);
		chk(16'(rxq[0]), 16'h00A5);
		chk(16'(irq), 16'h0001);
		put(16'h003C);
		wait_rx(2);
		chk(16'(rxq[1]), 16'h003C);
		repeat (100) @(posedge clk);
	endtask
	task automatic t_parity;
		for (int p = 0; p < 2; p++) begin
			rxq.delete();
			far_long <= 1'b1;
			wr_reg(asx_pkg::ADDR_CTRL, C_TX | C_LONG | C_PEN | (p ? C_ODD : 16'h0));
			put(16'h0107);
			wait_rx(1);
			chk(16'(rxq[0]), p ? 16'h0007 : 16'h0107);
			repeat (100) @(posedge clk);
		end
	endtask
	task automatic t_break;
		rxq.delete();
		far_long <= 1'b0;
		wr_reg(asx_pkg::ADDR_CTRL, C_TX | C_BRK);
		wait_rx(1);
		chk(16'(rxq[0][9]), 16'h0001);
		wr_reg(asx_pkg::ADDR_CTRL, C_TX);
		repeat (800) @(posedge clk);
		rxq.delete();
		put(16'h0055);
		wait_rx(1);
		chk(16'(rxq[0]), 16'h0055);
		repeat (100) @(posedge clk);
	endtask
	task automatic t_rx;
		wr_reg(asx_pkg::ADDR_CTRL, C_TX | C_RX);
		far_send(9'h03C);
		repeat (800) @(posedge clk);
		rd_reg(asx_pkg::ADDR_STAT, st);
		chk(16'(st[asx_pkg::SB_RXF]), 16'h0001);
		chk(16'(st[asx_pkg::SB_FRM]), 16'h0000);
		rd_reg(asx_pkg::ADDR_DATA, st);
		chk(st, 16'h003C);
		far_send(9'h011);
		far_send(9'h022);
		repeat (800) @(posedge clk);
		rd_reg(asx_pkg::ADDR_STAT, st);
		chk(16'(st[asx_pkg::SB_OVR]), 16'h0001);
		rd_reg(asx_pkg::ADDR_DATA, st);
		chk(st, 16'h0011);
	endtask
	task automatic t_disable;
		rxq.delete();
		put(16'h0081);
		for (int i = 0; i < 2000 && link.dev_tx !== 1'b0; i++)
			@(posedge clk);
		put(16'h0042);
		wr_reg(asx_pkg::ADDR_CTRL, 16'h0000);
		wait_rx(1);
		chk(16'(rxq[0]), 16'h0081);
		repeat (1000) @(posedge clk);
		chk(16'(rxq.size()), 16'h0001);
		chk(16'(link.dev_tx_oe), 16'h0000);
		wr_reg(asx_pkg::ADDR_CTRL, C_TX);
		wait_rx(2);
		chk(16'(rxq[1]), 16'h0042);
	endtask
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_tx_basic();
		t_parity();
		t_break();
		t_rx();
		t_disable();
		stop_test();
	end
endmodule
